// file: dv/mie_host.sv
// host processor model: register access and measurement feed
`timescale 1ns/1ps
`default_nettype none
module mie_host (
   input  wire logic                i_clk,
   output var mie_pkg::mie_regreq_s o_reg,
   output logic                     o_valid,
   output var mie_pkg::mie_sample_s o_sample
);
   logic [15:0] exp_q[$];
   initial begin
      o_reg = '0;
      o_valid = 1'b0;
      o_sample = '0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_reg = '{wr: 1'b1, rd: 1'b0, seq_end: 1'b0, addr: a, wdata: d};
      @(negedge i_clk);
      o_reg.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, e, m, input bit s);
      @(negedge i_clk);
      o_reg = '{wr: 1'b0, rd: 1'b1, seq_end: 1'b0, addr: a, wdata: 8'h00};
      exp_q.push_back({m, e});
      @(negedge i_clk);
      o_reg.rd = 1'b0;
      // sequence end on its own cycle, after the data read
      if (s) begin
         o_reg.seq_end = 1'b1;
         @(negedge i_clk);
         o_reg.seq_end = 1'b0;
      end
   endtask : rd
   task automatic smp(input logic [12:0] x, y, input logic [14:0] z,
                      input logic [2:0] f);
      @(negedge i_clk);
      o_sample = '{hall_resistance_value: 14'h0155, axis_z_value: z,
                   axis_y_value: y, axis_x_value: x, overflow: f};
      o_valid = 1'b1;
      @(negedge i_clk);
      o_valid = 1'b0;
   endtask : smp
endmodule : mie_host
`default_nettype wire

// file: dv/tb.sv
// self-checking testbench of the magnetometer interrupt engine
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                 clk, rst, valid, irq, irq_oe_n, frs, frs_oe_n;
   logic                 rd_seen = 1'b0;
   mie_pkg::mie_regreq_s req;
   mie_pkg::mie_sample_s smp;
   logic [7:0]           rdata, l_lvl, h_lvl, en, st;
   logic [12:0]          x, y;
   logic [14:0]          z;
   logic signed [15:0]   vx, vy, vz, lo, hi;
   logic [15:0]          note;
   int                   errors = 0, samples_checked = 0, seed;
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   mie_top i_mie_top (.I_CORE_CLK(clk), .I_RESET(rst), .I_REG(req),
      .I_SAMPLE_VALID(valid), .I_SAMPLE(smp), .O_RD_DATA(rdata),
      .O_IRQ_PIN(irq), .O_IRQ_PIN_OE_N(irq_oe_n), .O_FRESH_SAMPLE_PIN(frs),
      .O_FRESH_SAMPLE_PIN_OE_N(frs_oe_n));
   mie_host i_mie_host (.i_clk(clk), .o_reg(req), .o_valid(valid),
      .o_sample(smp));
   task automatic check(input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish
   // read data is settled by the falling edge after the read edge
   always @(posedge clk) rd_seen <= req.rd;
   always @(negedge clk) begin
      if (rd_seen) begin
         note = i_mie_host.exp_q.pop_front();
         check(rdata & note[15:8], note[7:0]);
      end
   end
   initial begin
      // the tests need well under a thousand clocks
      #200_000;
      errors++;
      tally_and_finish();
   end
   initial begin
      seed = 32'h8A5F;
      rst = 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      @(negedge clk);
      check({6'h00, irq_oe_n, frs_oe_n}, 8'h03);
      i_mie_host.rd(8'h4D, 8'h3F, 8'hFF, 1'b0);
      i_mie_host.rd(8'h4E, 8'h07, 8'hFF, 1'b0);
      i_mie_host.wr(8'h4A, 8'hFF);
      i_mie_host.rd(8'h4A, 8'h00, 8'hFF, 1'b0);
      i_mie_host.wr(8'h60, 8'h55);
      i_mie_host.rd(8'h60, 8'h00, 8'hFF, 1'b0);
      $display("test reset_and_map done");
      i_mie_host.wr(8'h4E, 8'hC7);
      i_mie_host.wr(8'h4F, 8'hFE);
      i_mie_host.wr(8'h50, 8'h02);
      i_mie_host.wr(8'h4D, 8'h00);
      i_mie_host.smp(13'h1FDF, 13'h0021, 15'h0000, 3'b000);
      @(negedge clk);
      check({4'h0, irq_oe_n, irq, frs, frs_oe_n}, 8'h06);
      i_mie_host.smp(13'h0000, 13'h0000, 15'h0000, 3'b000);
      i_mie_host.rd(8'h4A, 8'h11, 8'h7F, 1'b0);
      @(negedge clk);
      check({7'h00, irq}, 8'h00);
      i_mie_host.rd(8'h42, 8'h00, 8'hFF, 1'b1);
      @(negedge clk);
      check({7'h00, frs}, 8'h00);
      // x and y equal to their scaled levels raise nothing, z well above
      i_mie_host.smp(13'h1FE0, 13'h0020, 15'h3FFF, 3'b000);
      i_mie_host.rd(8'h4A, 8'h20, 8'h7F, 1'b0);
      i_mie_host.smp(13'h1000, 13'h0000, 15'h0000, 3'b001);
      @(negedge clk);
      check({7'h00, irq}, 8'h00);
      i_mie_host.rd(8'h43, 8'h80, 8'hFF, 1'b0);
      i_mie_host.rd(8'h4A, 8'h40, 8'h7F, 1'b0);
      i_mie_host.wr(8'h4D, 8'h7F);
      i_mie_host.smp(13'h1000, 13'h0000, 15'h0000, 3'b001);
      @(negedge clk);
      check({7'h00, irq}, 8'h01);
      i_mie_host.rd(8'h4A, 8'h40, 8'h7F, 1'b0);
      // overrun: fresh flag is still set, no data read has ended since
      i_mie_host.wr(8'h4D, 8'hFF);
      i_mie_host.smp(13'h0000, 13'h0000, 15'h0000, 3'b000);
      i_mie_host.rd(8'h4A, 8'h80, 8'hFF, 1'b0);
      $display("test latched done");
      // non-latched, both pins active low, random levels and axes
      i_mie_host.wr(8'h4E, 8'hC0);
      repeat (24) begin
         l_lvl = 8'($random(seed));
         h_lvl = 8'($random(seed));
         en = 8'($random(seed)) & 8'h3F;
         x = 13'($random(seed));
         y = 13'($random(seed));
         z = 15'($random(seed));
         if (x == 13'h1000) x = 13'h0FFF;
         if (y == 13'h1000) y = 13'h0FFF;
         i_mie_host.wr(8'h4F, l_lvl);
         i_mie_host.wr(8'h50, h_lvl);
         i_mie_host.wr(8'h4D, {2'b01, en[5:0]});
         i_mie_host.smp(x, y, z, 3'b000);
         lo = {{4{l_lvl[7]}}, l_lvl, 4'h0};
         hi = {{4{h_lvl[7]}}, h_lvl, 4'h0};
         vx = {{3{x[12]}}, x};
         vy = {{3{y[12]}}, y};
         vz = {z[14], z};
         st = {2'b00, vz > hi && !en[5], vy > hi && !en[4],
               vx > hi && !en[3], vz < lo && !en[2], vy < lo && !en[1],
               vx < lo && !en[0]};
         i_mie_host.rd(8'h4A, st, 8'h3F, 1'b0);
         check({6'h00, irq, frs}, {6'h00, ~|st, 1'b0});
      end
      $display("test random_non_latched done");
      i_mie_host.wr(8'h4E, 8'h00);
      @(negedge clk);
      check({6'h00, irq_oe_n, frs_oe_n}, 8'h03);
      $display("test pin_disable done");
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire

// file: rtl/mie_cmp.sv
// one axis threshold comparator of the magnetometer interrupt engine
`timescale 1ns/1ps
`default_nettype none
module mie_cmp #(
   parameter int                AXIS_W    = 15,
   parameter bit                SKIP_CODE = 1'b0,
   parameter logic [AXIS_W-1:0] CODE      = {AXIS_W{1'b0}}
) (
   input  wire logic signed [AXIS_W-1:0] i_value,
   input  wire logic [7:0]               i_low_level,
   input  wire logic [7:0]               i_high_level,
   output logic                          o_below,
   output logic                          o_above
);
   localparam int SH = mie_pkg::MIE_THR_SHIFT;

   // the scaled level must fit the axis with its sign bit
   if (AXIS_W < 8 + SH + 1) begin : g_bad_width
      $error("mie_cmp: AXIS_W too narrow for scaled threshold");
   end

   wire logic signed [AXIS_W-1:0] low_scaled;
   wire logic signed [AXIS_W-1:0] high_scaled;
   wire logic                     is_code;

   assign low_scaled  = {{(AXIS_W-8-SH){i_low_level[7]}}, i_low_level,
                         {SH{1'b0}}};
   assign high_scaled = {{(AXIS_W-8-SH){i_high_level[7]}}, i_high_level,
                         {SH{1'b0}}};
   assign is_code     = SKIP_CODE && (i_value == $signed(CODE));
   assign o_below     = (i_value < low_scaled) && !is_code;
   assign o_above     = i_value > high_scaled;
endmodule : mie_cmp
`default_nettype wire

// file: rtl/mie_pkg.sv
// constants and carriers shared by the magnetometer interrupt engine
package mie_pkg;

   // ************************************************************
   // register space
   // ************************************************************
   localparam logic [7:0] MIE_ADDR_FIRST   = 8'h40;
   localparam logic [7:0] MIE_ADDR_LAST    = 8'h71;
   localparam logic [7:0] MIE_ADDR_RO_LAST = 8'h4A;
   localparam logic [7:0] MIE_ADDR_X_LSB   = 8'h42;
   localparam logic [7:0] MIE_ADDR_X_MSB   = 8'h43;
   localparam logic [7:0] MIE_ADDR_Y_LSB   = 8'h44;
   localparam logic [7:0] MIE_ADDR_Y_MSB   = 8'h45;
   localparam logic [7:0] MIE_ADDR_Z_LSB   = 8'h46;
   localparam logic [7:0] MIE_ADDR_Z_MSB   = 8'h47;
   localparam logic [7:0] MIE_ADDR_H_LSB   = 8'h48;
   localparam logic [7:0] MIE_ADDR_H_MSB   = 8'h49;
   localparam logic [7:0] MIE_ADDR_STAT    = 8'h4A;
   localparam logic [7:0] MIE_ADDR_INT_EN  = 8'h4D;
   localparam logic [7:0] MIE_ADDR_CFG     = 8'h4E;
   localparam logic [7:0] MIE_ADDR_LOW     = 8'h4F;
   localparam logic [7:0] MIE_ADDR_HIGH    = 8'h50;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0] MIE_STAT_RST     = 8'h00;
   localparam logic [7:0] MIE_INT_EN_RST   = 8'h3F;
   localparam logic [7:0] MIE_CFG_RST      = 8'h07;
   localparam logic [7:0] MIE_THR_RST      = 8'h00;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int MIE_STAT_OVR     = 7;
   localparam int MIE_STAT_OVF     = 6;
   localparam int MIE_STAT_HIGH    = 3;
   localparam int MIE_STAT_LOW     = 0;
   localparam int MIE_EN_OVR       = 7;
   localparam int MIE_EN_OVF       = 6;
   localparam int MIE_CFG_FRESH_EN = 7;
   localparam int MIE_CFG_IRQ_EN   = 6;
   localparam int MIE_CFG_FRESH_POL = 2;
   localparam int MIE_CFG_LATCH    = 1;
   localparam int MIE_CFG_IRQ_POL  = 0;

   // ************************************************************
   // data widths and codes
   // ************************************************************
   localparam int MIE_XY_W      = 13;
   localparam int MIE_Z_W       = 15;
   localparam int MIE_H_W       = 14;
   localparam int MIE_AXIS_W    = 15;
   localparam int MIE_THR_SHIFT = 4;
   localparam logic [MIE_XY_W-1:0] MIE_XY_OVF_CODE = 13'h1000;
   localparam logic [MIE_Z_W-1:0]  MIE_Z_OVF_CODE  = 15'h4000;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef logic [7:0] mie_byte_t;

   typedef struct packed {
      logic                hall_resistance_value;
   } mie_unused_s;

   typedef struct packed {
      logic [MIE_H_W-1:0]  hall_resistance_value;
      logic [MIE_Z_W-1:0]  axis_z_value;
      logic [MIE_XY_W-1:0] axis_y_value;
      logic [MIE_XY_W-1:0] axis_x_value;
      logic [2:0]          overflow;
   } mie_sample_s;

   typedef struct packed {
      logic                wr;
      logic                rd;
      logic                seq_end;
      mie_byte_t           addr;
      mie_byte_t           wdata;
   } mie_regreq_s;

endpackage : mie_pkg

// file: rtl/mie_top.sv
// interrupt engine of the three-axis magnetometer, register side and pins
`timescale 1ns/1ps
`default_nettype none
module mie_top #(
   parameter int AXIS_W = mie_pkg::MIE_AXIS_W
) (
   input  wire logic                 I_CORE_CLK,
   input  wire logic                 I_RESET,
   input  wire mie_pkg::mie_regreq_s I_REG,
   input  wire logic                 I_SAMPLE_VALID,
   input  wire mie_pkg::mie_sample_s I_SAMPLE,
   output logic [7:0]                O_RD_DATA,
   output logic                      O_IRQ_PIN,
   output logic                      O_IRQ_PIN_OE_N,
   output logic                      O_FRESH_SAMPLE_PIN,
   output logic                      O_FRESH_SAMPLE_PIN_OE_N
);

   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (AXIS_W < mie_pkg::MIE_Z_W || AXIS_W > 31) begin : g_bad_axis
      $error("mie_top: AXIS_W must hold the widest axis");
   end

   localparam logic [AXIS_W-1:0] XY_CODE_WIDE =
      {{(AXIS_W-mie_pkg::MIE_XY_W){mie_pkg::MIE_XY_OVF_CODE[
         mie_pkg::MIE_XY_W-1]}}, mie_pkg::MIE_XY_OVF_CODE};

   // ************************************************************
   // state
   // ************************************************************
   logic [mie_pkg::MIE_XY_W-1:0] axis_x_value_r;
   logic [mie_pkg::MIE_XY_W-1:0] axis_y_value_r;
   logic [mie_pkg::MIE_Z_W-1:0]  axis_z_value_r;
   logic [mie_pkg::MIE_H_W-1:0]  hall_resistance_value_r;
   mie_pkg::mie_byte_t           stat_r;
   mie_pkg::mie_byte_t           stat_nxt;
   mie_pkg::mie_byte_t           int_en_r;
   mie_pkg::mie_byte_t           cfg_r;
   mie_pkg::mie_byte_t           low_level_r;
   mie_pkg::mie_byte_t           high_level_r;
   logic                         fresh_r;
   logic                         fresh_nxt;
   logic                         data_seen_r;
   logic [7:0]                   rd_data_r;
   logic                         irq_pin_r;
   logic                         irq_oe_n_r;
   logic                         fresh_pin_r;
   logic                         fresh_oe_n_r;

   // ************************************************************
   // incoming sample, saturated
   // ************************************************************
   wire logic [mie_pkg::MIE_XY_W-1:0] sat_x;
   wire logic [mie_pkg::MIE_XY_W-1:0] sat_y;
   wire logic [mie_pkg::MIE_Z_W-1:0]  sat_z;
   wire logic signed [AXIS_W-1:0]     cmp_val [3];
   wire logic [2:0]                   below;
   wire logic [2:0]                   above;

   assign sat_x = I_SAMPLE.overflow[0] ? mie_pkg::MIE_XY_OVF_CODE
                                        : I_SAMPLE.axis_x_value;
   assign sat_y = I_SAMPLE.overflow[1] ? mie_pkg::MIE_XY_OVF_CODE
                                        : I_SAMPLE.axis_y_value;
   assign sat_z = I_SAMPLE.overflow[2] ? mie_pkg::MIE_Z_OVF_CODE
                                        : I_SAMPLE.axis_z_value;

   assign cmp_val[0] = {{(AXIS_W-mie_pkg::MIE_XY_W){sat_x[
                          mie_pkg::MIE_XY_W-1]}}, sat_x};
   assign cmp_val[1] = {{(AXIS_W-mie_pkg::MIE_XY_W){sat_y[
                          mie_pkg::MIE_XY_W-1]}}, sat_y};
   assign cmp_val[2] = {{(AXIS_W-mie_pkg::MIE_Z_W){sat_z[
                          mie_pkg::MIE_Z_W-1]}}, sat_z};

   // ************************************************************
   // per-axis comparators
   // ************************************************************
   // comparing the saturated value keeps status and data consistent
   for (genvar a = 0; a < 3; a++) begin : g_axis
      mie_cmp #(
         .AXIS_W    (AXIS_W),
         .SKIP_CODE (a < 2),
         .CODE      (XY_CODE_WIDE)
      ) u_cmp (
         .i_value      (cmp_val[a]),
         .i_low_level  (low_level_r),
         .i_high_level (high_level_r),
         .o_below      (below[a]),
         .o_above      (above[a])
      );
   end

   // ************************************************************
   // register decode
   // ************************************************************
   wire logic       in_space;
   wire logic       wr_ok;
   wire logic       rd_stat;
   wire logic       rd_data;
   wire logic       latched;
   wire logic [2:0] below_limit_mask_axes;
   wire logic [2:0] above_limit_mask_axes;
   wire logic       fresh_pin_level_select;

   assign in_space = (I_REG.addr >= mie_pkg::MIE_ADDR_FIRST) &&
                     (I_REG.addr <= mie_pkg::MIE_ADDR_LAST);
   assign wr_ok    = I_REG.wr && in_space &&
                     (I_REG.addr > mie_pkg::MIE_ADDR_RO_LAST);
   assign rd_stat  = I_REG.rd && (I_REG.addr == mie_pkg::MIE_ADDR_STAT);
   assign rd_data  = I_REG.rd &&
                     (I_REG.addr >= mie_pkg::MIE_ADDR_X_LSB) &&
                     (I_REG.addr <= mie_pkg::MIE_ADDR_H_MSB);
   assign latched  = cfg_r[mie_pkg::MIE_CFG_LATCH];
   assign below_limit_mask_axes = int_en_r[mie_pkg::MIE_STAT_LOW +: 3];
   assign above_limit_mask_axes = int_en_r[mie_pkg::MIE_STAT_HIGH +: 3];
   assign fresh_pin_level_select = cfg_r[mie_pkg::MIE_CFG_FRESH_POL];

   // ************************************************************
   // status next value
   // ************************************************************
   wire logic [5:0] thr_on;
   wire logic [6:0] cond;
   wire logic [6:0] keep;
   wire logic [7:0] base;
   wire logic       overrun;
   wire logic       fresh_clr;

   assign thr_on  = ~{above_limit_mask_axes, below_limit_mask_axes};
   assign cond    = {|I_SAMPLE.overflow, {above, below} & thr_on};
   // disabled threshold bits drop at next sample
   assign keep    = {1'b1, thr_on};
   // status read clears bits 6:0 in latched mode, the overrun bit in both modes
   assign base[6:0] = (rd_stat && latched) ? 7'h00 : stat_r[6:0];
   assign base[7]   = rd_stat ? 1'b0 : stat_r[mie_pkg::MIE_STAT_OVR];
   assign overrun = I_SAMPLE_VALID && fresh_r &&
                    int_en_r[mie_pkg::MIE_EN_OVR];
   // clear once the read sequence ends
   assign fresh_clr = I_REG.seq_end && (data_seen_r || rd_data);

   // a sample in the clearing cycle wins over the clear
   always_comb begin
      stat_nxt = base;
      // status moves with the data registers
      if (I_SAMPLE_VALID) begin
         // one mode for threshold and overflow
         if (latched) begin
            stat_nxt[6:0] = (base[6:0] & keep) | cond;
         end else begin
            stat_nxt[6:0] = cond;
         end
      end
      if (overrun) begin
         stat_nxt[mie_pkg::MIE_STAT_OVR] = 1'b1;
      end
   end

   // raised by a new data set
   assign fresh_nxt = I_SAMPLE_VALID ? 1'b1 : (fresh_clr ? 1'b0 : fresh_r);

   // ************************************************************
   // pin levels
   // ************************************************************
   wire logic irq_act;
   wire logic irq_lvl;
   wire logic fresh_lvl;

   // threshold flags and the enabled overflow flag reach the pin, overrun does not
   assign irq_act   = (|stat_r[5:0]) ||
                      (stat_r[mie_pkg::MIE_STAT_OVF] &&
                       int_en_r[mie_pkg::MIE_EN_OVF]);
   assign irq_lvl   = irq_act ~^ cfg_r[mie_pkg::MIE_CFG_IRQ_POL];
   assign fresh_lvl = fresh_r ~^ fresh_pin_level_select;

   // ************************************************************
   // read multiplexer
   // ************************************************************
   wire logic [7:0] rd_mux;

   // reserved and unused read as zero
   assign rd_mux =
      (I_REG.addr == mie_pkg::MIE_ADDR_X_LSB) ? {axis_x_value_r[4:0], 3'h0} :
      (I_REG.addr == mie_pkg::MIE_ADDR_X_MSB) ? axis_x_value_r[12:5] :
      (I_REG.addr == mie_pkg::MIE_ADDR_Y_LSB) ? {axis_y_value_r[4:0], 3'h0} :
      (I_REG.addr == mie_pkg::MIE_ADDR_Y_MSB) ? axis_y_value_r[12:5] :
      (I_REG.addr == mie_pkg::MIE_ADDR_Z_LSB) ? {axis_z_value_r[6:0], 1'h0} :
      (I_REG.addr == mie_pkg::MIE_ADDR_Z_MSB) ? axis_z_value_r[14:7] :
      (I_REG.addr == mie_pkg::MIE_ADDR_H_LSB) ?
         {hall_resistance_value_r[5:0], 1'h0, fresh_r} :
      (I_REG.addr == mie_pkg::MIE_ADDR_H_MSB) ?
         hall_resistance_value_r[13:6] :
      (I_REG.addr == mie_pkg::MIE_ADDR_STAT)  ? stat_r :
      (I_REG.addr == mie_pkg::MIE_ADDR_INT_EN) ? int_en_r :
      (I_REG.addr == mie_pkg::MIE_ADDR_CFG)   ? cfg_r :
      (I_REG.addr == mie_pkg::MIE_ADDR_LOW)   ? low_level_r :
      (I_REG.addr == mie_pkg::MIE_ADDR_HIGH)  ? high_level_r : 8'h00;

   // ************************************************************
   // data and status registers
   // ************************************************************
   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         axis_x_value_r          <= 13'h0000;
         axis_y_value_r          <= 13'h0000;
         axis_z_value_r          <= 15'h0000;
         hall_resistance_value_r <= 14'h0000;
      end else if (I_SAMPLE_VALID) begin
         axis_x_value_r          <= sat_x;
         axis_y_value_r          <= sat_y;
         axis_z_value_r          <= sat_z;
         hall_resistance_value_r <= I_SAMPLE.hall_resistance_value;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         stat_r      <= mie_pkg::MIE_STAT_RST;
         fresh_r     <= 1'b0;
         data_seen_r <= 1'b0;
      end else begin
         stat_r      <= stat_nxt;
         fresh_r     <= fresh_nxt;
         data_seen_r <= !I_REG.seq_end && (data_seen_r || rd_data);
      end
   end

   // ************************************************************
   // writable registers
   // ************************************************************
   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         int_en_r     <= mie_pkg::MIE_INT_EN_RST;
         cfg_r        <= mie_pkg::MIE_CFG_RST;
         low_level_r  <= mie_pkg::MIE_THR_RST;
         high_level_r <= mie_pkg::MIE_THR_RST;
      end else if (wr_ok) begin
         if (I_REG.addr == mie_pkg::MIE_ADDR_INT_EN) int_en_r <= I_REG.wdata;
         // host sets the fresh pin enable
         if (I_REG.addr == mie_pkg::MIE_ADDR_CFG) cfg_r <= I_REG.wdata;
         if (I_REG.addr == mie_pkg::MIE_ADDR_LOW) low_level_r <= I_REG.wdata;
         if (I_REG.addr == mie_pkg::MIE_ADDR_HIGH) high_level_r <= I_REG.wdata;
      end
   end

   // ************************************************************
   // output flops
   // ************************************************************
   // pins lag status by one clock so every output is a flop
   always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         rd_data_r    <= 8'h00;
         irq_pin_r    <= 1'b0;
         irq_oe_n_r   <= 1'b1;
         fresh_pin_r  <= 1'b0;
         fresh_oe_n_r <= 1'b1;
      end else begin
         if (I_REG.rd) rd_data_r <= rd_mux;
         irq_pin_r    <= irq_lvl;
         fresh_pin_r  <= fresh_lvl;
         irq_oe_n_r   <= !cfg_r[mie_pkg::MIE_CFG_IRQ_EN];
         fresh_oe_n_r <= !cfg_r[mie_pkg::MIE_CFG_FRESH_EN];
      end
   end

   assign O_RD_DATA               = rd_data_r;
   assign O_IRQ_PIN               = irq_pin_r;
   assign O_IRQ_PIN_OE_N          = irq_oe_n_r;
   assign O_FRESH_SAMPLE_PIN      = fresh_pin_r;
   assign O_FRESH_SAMPLE_PIN_OE_N = fresh_oe_n_r;

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RESET);

   property p_fresh_set;
      I_SAMPLE_VALID |=> fresh_r ##1 (O_FRESH_SAMPLE_PIN ==
                                      $past(fresh_pin_level_select));
   endproperty
   a_fresh_set: assert property (p_fresh_set)
      else $error("fresh flag or pin not raised by sample");

   property p_fresh_clr;
      fresh_clr && !I_SAMPLE_VALID |=> !fresh_r && !data_seen_r;
   endproperty
   a_fresh_clr: assert property (p_fresh_clr)
      else $error("fresh flag not cleared after data read");

   property p_latch_hold;
      latched && !I_SAMPLE_VALID && !rd_stat && stat_r[0]
         && !wr_ok |=> stat_r[0];
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latched status bit dropped without read");

   property p_latch_read;
      latched && rd_stat && !I_SAMPLE_VALID |=> stat_r[6:0] == 7'h00;
   endproperty
   a_latch_read: assert property (p_latch_read)
      else $error("status read did not clear latched bits");

   property p_follow;
      !latched && I_SAMPLE_VALID && !below[0] |=> !stat_r[0];
   endproperty
   a_follow: assert property (p_follow)
      else $error("non-latched bit kept without condition");

   property p_high_set;
      I_SAMPLE_VALID && above[1] && !above_limit_mask_axes[1]
         |=> stat_r[4] ##1 (O_IRQ_PIN == $past(cfg_r[0]));
   endproperty
   a_high_set: assert property (p_high_set)
      else $error("high flag did not reach status and pin");

   property p_saturate;
      I_SAMPLE_VALID && I_SAMPLE.overflow[2]
         |=> axis_z_value_r == mie_pkg::MIE_Z_OVF_CODE && stat_r[6];
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("overflowed axis not saturated or flagged");

   property p_code_low;
      I_SAMPLE_VALID && I_SAMPLE.overflow[0] |-> !below[0];
   endproperty
   a_code_low: assert property (p_code_low)
      else $error("low flag raised on overflow code");

   property p_read_only;
      I_REG.wr && (I_REG.addr <= mie_pkg::MIE_ADDR_RO_LAST)
         |=> $stable(int_en_r) && $stable(cfg_r) && $stable(low_level_r)
             && $stable(high_level_r)
             && ($stable(stat_r) || $past(I_SAMPLE_VALID) || $past(I_REG.rd));
   endproperty
   a_read_only: assert property (p_read_only)
      else $error("write accepted in read-only range");

   property p_float;
      !cfg_r[mie_pkg::MIE_CFG_IRQ_EN] |=> O_IRQ_PIN_OE_N;
   endproperty
   a_float: assert property (p_float)
      else $error("irq pin driven while disabled");

   c_latch_read: cover property (latched && rd_stat && stat_r[0]);
   c_overrun: cover property (overrun ##1 stat_r[7]);
   c_fresh_cycle: cover property (I_SAMPLE_VALID ##[1:20] fresh_clr);
endmodule : mie_top
`default_nettype wire
